/* xcvr_ctrl_params.svh */
`ifndef XCVR_CTRL_PARAMS_SVH
`define XCVR_CTRL_PARAMS_SVH

// ==========================================
// clock and link timing
`define CORE_CLK_PERIOD_NS  20
`define BIT_TIME_PS         1000
`define PLL_SETTLE_US       25
`define PLL_START_BITS      20480
`define RX_INIT_BITS        300
`define WORD_ALIGN_BITS     160

// ==========================================
// derived cycle counts, rounded up, full and half speed
`define CYC_PS              (`CORE_CLK_PERIOD_NS * 1000)
`define PLL_CYC_FULL  ((`PLL_START_BITS * `BIT_TIME_PS + `PLL_SETTLE_US * 1000000 + `CYC_PS - 1) / `CYC_PS)
`define PLL_CYC_HALF  ((`PLL_START_BITS * `BIT_TIME_PS * 2 + `PLL_SETTLE_US * 1000000 + `CYC_PS - 1) / `CYC_PS)
`define RXI_CYC_FULL  ((`RX_INIT_BITS * `BIT_TIME_PS + `CYC_PS - 1) / `CYC_PS)
`define RXI_CYC_HALF  ((`RX_INIT_BITS * `BIT_TIME_PS * 2 + `CYC_PS - 1) / `CYC_PS)
`define WA_CYC_FULL   ((`WORD_ALIGN_BITS * `BIT_TIME_PS + `CYC_PS - 1) / `CYC_PS)
`define WA_CYC_HALF   ((`WORD_ALIGN_BITS * `BIT_TIME_PS * 2 + `CYC_PS - 1) / `CYC_PS)
`define TIMER_W             12

// ==========================================
// reference clock activity window in core cycles
`define REFCLK_LOSS_CYC     16
`define REFCLK_CNT_W        5

// ==========================================
// idle code group values
`define IDLE_BYTE           8'hBC
`define IDLE_GROUP_NEG      10'h0FA
`define IDLE_GROUP_POS      10'h305

`endif

/* xcvr_ctrl_pkg.sv */
package xcvr_ctrl_pkg;

    // ==========================================
    // startup sequencer states
    typedef enum logic [2:0] {
        ST_WAIT_CLK = 3'h0,
        ST_PLL      = 3'h1,
        ST_RX_INIT  = 3'h2,
        ST_WORD_AL  = 3'h3,
        ST_RUN      = 3'h4,
        ST_STANDBY  = 3'h5
    } startup_state_t;

    // ==========================================
    // configuration pins, asynchronous to core_clk
    typedef struct packed {
        logic diff_refclk_select;
        logic half_speed_enable;
        logic word_sync_select_hi;
        logic word_sync_select_lo;
        logic low_power_hold;
        logic relay_mode_enable;
        logic ten_bit_passthrough_enable;
        logic byte_align_enable;
        logic recovered_clock_timing_enable;
        logic idle_insert_remove_enable;
        logic rx_clk_center_select;
    } cfg_t;

    // received unit from one link receiver
    typedef struct packed {
        logic       valid;
        logic [9:0] group;
        logic [7:0] data;
        logic       is_ctrl;
        logic       code_err;
        logic       disp_err;
    } link_rx_t;

    // unit offered to one link transmitter
    typedef struct packed {
        logic       valid;
        logic [9:0] group;
        logic [7:0] data;
        logic       is_ctrl;
    } link_tx_t;

    // sequencer status seen by the rest of the device
    typedef struct packed {
        logic pll_locked;
        logic rx_init_active;
        logic word_align_active;
        logic run;
        logic serial_tx_disable;
        logic core_clock_enable;
    } status_t;

    // datapath steering
    typedef struct packed {
        logic refclk_diff_used;
        logic encoder_bypass;
        logic disparity_check_en;
        logic tx_recovered_timing;
        logic rx_if_centered;
        logic rx_if_half_rate;
        logic relay_cfg_error;
    } steer_t;

endpackage

/* transceiver_startup_repeater_ctrl.sv */
`timescale 1ns/100ps
`include "xcvr_ctrl_params.svh"

module transceiver_startup_repeater_ctrl
    import xcvr_ctrl_pkg::*;
(
    input  wire logic                  core_clk,
    input  wire logic                  rst_b,
    input  wire logic                  refclk_diff_pin,
    input  wire logic                  refclk_se_pin,
    input  wire cfg_t                  cfg_pins,
    input  wire link_rx_t [1:0]        rx_link,
    input  wire link_tx_t [1:0]        local_tx,
    input  wire logic     [1:0]        tx_slot,
    input  wire logic                  flag_clear,
    output startup_state_t             startup_state,
    output status_t                    status,
    output steer_t                     steer,
    output link_tx_t      [1:0]        tx_link,
    output logic          [1:0]        relay_code_err,
    output logic          [1:0]        relay_disp_err,
    output logic          [1:0]        overrun_flag,
    output logic          [1:0]        underrun_flag
);

    // ==========================================
    // pin synchronisers
    cfg_t        cfg_meta_reg;      // first stage, read only by cfg_reg
    cfg_t        cfg_reg;           // settled configuration
    logic [1:0]  clk_meta_reg;      // first stage of refclk samples
    logic [1:0]  clk_sync_reg;      // second stage of refclk samples
    logic        clk_prev_reg;      // previous selected sample

    // two flops on every asynchronous pin
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            cfg_meta_reg <= '0;
            cfg_reg      <= '0;
            clk_meta_reg <= 2'h0;
            clk_sync_reg <= 2'h0;
        end else begin
            cfg_meta_reg <= cfg_pins;
            cfg_reg      <= cfg_meta_reg;
            clk_meta_reg <= {refclk_diff_pin, refclk_se_pin};
            clk_sync_reg <= clk_meta_reg;
        end
    end

    // ==========================================
    // reference clock selection and presence
    wire logic clk_sel_sample;      // sample of the chosen source
    wire logic clk_toggle;          // source moved since last cycle

    assign clk_sel_sample = cfg_reg.diff_refclk_select ? clk_sync_reg[1]
                                                       : clk_sync_reg[0];
    assign clk_toggle     = clk_sel_sample ^ clk_prev_reg;

    logic [`REFCLK_CNT_W-1:0] quiet_cnt_reg;   // cycles since last toggle
    logic                     clk_present_reg; // refclk seen recently

    // a refclk at an exact multiple of core_clk can alias to a steady
    // level; the window only tells a stopped clock from a running one
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            clk_prev_reg    <= 1'b0;
            quiet_cnt_reg   <= '0;
            clk_present_reg <= 1'b0;
        end else begin
            clk_prev_reg <= clk_sel_sample;
            if (clk_toggle) begin
                quiet_cnt_reg   <= '0;
                clk_present_reg <= 1'b1;
            end else if (quiet_cnt_reg == `REFCLK_CNT_W'(`REFCLK_LOSS_CYC)) begin
                clk_present_reg <= 1'b0;
            end else begin
                quiet_cnt_reg <= quiet_cnt_reg + `REFCLK_CNT_W'(1);
            end
        end
    end

    // ==========================================
    // step durations, half speed doubles bit times
    wire logic [`TIMER_W-1:0] pll_cyc;   // pll startup length
    wire logic [`TIMER_W-1:0] rxi_cyc;   // receiver init length
    wire logic [`TIMER_W-1:0] wa_cyc;    // word alignment length
    wire logic                ws_en;     // word alignment wanted
    wire logic                standby;   // standby requested

    assign pll_cyc = cfg_reg.half_speed_enable ? `TIMER_W'(`PLL_CYC_HALF)
                                               : `TIMER_W'(`PLL_CYC_FULL);
    assign rxi_cyc = cfg_reg.half_speed_enable ? `TIMER_W'(`RXI_CYC_HALF)
                                               : `TIMER_W'(`RXI_CYC_FULL);
    assign wa_cyc  = cfg_reg.half_speed_enable ? `TIMER_W'(`WA_CYC_HALF)
                                               : `TIMER_W'(`WA_CYC_FULL);
    assign ws_en   = cfg_reg.word_sync_select_hi | cfg_reg.word_sync_select_lo;
    assign standby = cfg_reg.low_power_hold;

    // ==========================================
    // startup sequencer
    startup_state_t           state_reg;   // current step
    startup_state_t           state_next;  // next step
    logic [`TIMER_W-1:0]      timer_reg;   // cycles left in the step
    logic                     timer_load;  // restart timer
    logic [`TIMER_W-1:0]      timer_val;   // value loaded on restart
    wire logic                timer_done;  // step time elapsed

    assign timer_done = (timer_reg == '0);

    // step order and standby handling
    always_comb begin
        state_next = state_reg;
        timer_load = 1'b0;
        timer_val  = '0;
        case (state_reg)
            ST_WAIT_CLK: begin
                // no trigger besides a running refclk
                if (clk_present_reg) begin
                    state_next = ST_PLL;
                    timer_load = 1'b1;
                    timer_val  = pll_cyc;
                end
            end
            ST_PLL: begin
                // pll keeps locking even under standby
                if (timer_done) begin
                    if (standby) begin
                        state_next = ST_STANDBY;
                    end else begin
                        state_next = ST_RX_INIT;
                        timer_load = 1'b1;
                        timer_val  = rxi_cyc;
                    end
                end
            end
            ST_RX_INIT: begin
                if (standby) begin
                    state_next = ST_STANDBY;
                end else if (timer_done) begin
                    if (ws_en) begin
                        // word align only once bytes are framed
                        state_next = ST_WORD_AL;
                        timer_load = 1'b1;
                        timer_val  = wa_cyc;
                    end else begin
                        state_next = ST_RUN;
                    end
                end
            end
            ST_WORD_AL: begin
                if (standby) begin
                    state_next = ST_STANDBY;
                end else if (timer_done) begin
                    state_next = ST_RUN;
                end
            end
            ST_RUN: begin
                if (standby) begin
                    state_next = ST_STANDBY;
                end
            end
            ST_STANDBY: begin
                // pll is still locked, skip its step on exit
                if (!standby) begin
                    state_next = ST_RX_INIT;
                    timer_load = 1'b1;
                    timer_val  = rxi_cyc;
                end
            end
            default: begin
                state_next = ST_WAIT_CLK;
            end
        endcase
    end

    // state and step timer; reset low restarts everything
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= ST_WAIT_CLK;
            timer_reg <= '0;
        end else begin
            state_reg <= state_next;
            if (timer_load) begin
                timer_reg <= timer_val - `TIMER_W'(1);
            end else if (!timer_done) begin
                timer_reg <= timer_reg - `TIMER_W'(1);
            end
        end
    end

    // ==========================================
    // status and steering decode
    status_t   status_next;  // decoded from next state
    steer_t    steer_next;   // decoded from configuration
    wire logic relay;        // relay mode active
    wire logic tbi_relay;    // relay with raw groups

    assign relay     = cfg_reg.relay_mode_enable;
    assign tbi_relay = relay & cfg_reg.ten_bit_passthrough_enable;

    assign status_next.pll_locked        = (state_next != ST_WAIT_CLK) &&
                                           (state_next != ST_PLL);
    assign status_next.rx_init_active    = (state_next == ST_RX_INIT);
    assign status_next.word_align_active = (state_next == ST_WORD_AL);
    assign status_next.run               = (state_next == ST_RUN);
    assign status_next.serial_tx_disable = (state_next != ST_RUN);
    assign status_next.core_clock_enable = (state_next != ST_STANDBY);

    assign steer_next.refclk_diff_used    = cfg_reg.diff_refclk_select;
    assign steer_next.encoder_bypass      = tbi_relay;
    assign steer_next.disparity_check_en  = ~tbi_relay;
    assign steer_next.tx_recovered_timing = cfg_reg.recovered_clock_timing_enable
                                            & ~relay;
    assign steer_next.rx_if_centered      = cfg_reg.rx_clk_center_select;
    assign steer_next.rx_if_half_rate     = cfg_reg.half_speed_enable;
    assign steer_next.relay_cfg_error     = relay & (~cfg_reg.byte_align_enable |
                                            ~cfg_reg.idle_insert_remove_enable);

    // registered status so outputs come from flops
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            status <= '0;
            steer  <= '0;
        end else begin
            status <= status_next;
            steer  <= steer_next;
        end
    end

    assign startup_state = state_reg;

    // ==========================================
    // per-link relay and transmit path
    genvar li;
    generate
        for (li = 0; li < 2; li = li + 1) begin : g_link
            link_tx_t  hold_reg;    // last unit taken from receiver
            logic      pend_reg;    // hold not yet transmitted
            wire logic rx_idle;     // incoming unit is an idle
            wire logic hold_idle;   // held unit is an idle
            wire logic busy;        // hold full and not draining
            wire logic drop_ok;     // idle may be discarded
            wire logic take;        // load incoming unit
            wire logic ovr_evt;     // data lost to overrun
            wire logic und_evt;     // slot with nothing safe to repeat
            link_tx_t  rx_unit;     // incoming unit reshaped
            link_tx_t  tx_next;     // next transmitter word

            assign rx_idle   = tbi_relay ?
                               ((rx_link[li].group == `IDLE_GROUP_NEG) ||
                                (rx_link[li].group == `IDLE_GROUP_POS)) :
                               (rx_link[li].is_ctrl &&
                                (rx_link[li].data == `IDLE_BYTE));
            assign hold_idle = tbi_relay ?
                               ((hold_reg.group == `IDLE_GROUP_NEG) ||
                                (hold_reg.group == `IDLE_GROUP_POS)) :
                               (hold_reg.is_ctrl &&
                                (hold_reg.data == `IDLE_BYTE));
            assign busy      = pend_reg & ~tx_slot[li];
            assign drop_ok   = cfg_reg.idle_insert_remove_enable & rx_idle;
            assign take      = relay & rx_link[li].valid & ~(busy & drop_ok);
            assign ovr_evt   = relay & rx_link[li].valid & busy & ~drop_ok;
            assign und_evt   = relay & status.run & tx_slot[li] & ~pend_reg &
                               ~(cfg_reg.idle_insert_remove_enable & hold_idle);

            // raw group passes untouched, byte goes to the encoder
            assign rx_unit.valid   = 1'b1;
            assign rx_unit.group   = rx_link[li].group;
            assign rx_unit.data    = rx_link[li].data;
            assign rx_unit.is_ctrl = rx_link[li].is_ctrl;

            // relay repeats the held unit on every reference slot while status.run is set
            assign tx_next.valid   = status.run & tx_slot[li] &
                                     (relay ? 1'b1 : local_tx[li].valid);
            assign tx_next.group   = relay ? hold_reg.group : local_tx[li].group;
            assign tx_next.data    = relay ? hold_reg.data : local_tx[li].data;
            assign tx_next.is_ctrl = relay ? hold_reg.is_ctrl
                                           : local_tx[li].is_ctrl;

            // hold register and pending flag
            always_ff @(posedge core_clk or negedge rst_b) begin
                if (!rst_b) begin
                    hold_reg <= '0;
                    pend_reg <= 1'b0;
                end else begin
                    if (take) begin
                        hold_reg <= rx_unit;
                    end
                    pend_reg <= take | busy;
                end
            end

            // transmit word, errors and sticky drift flags
            always_ff @(posedge core_clk or negedge rst_b) begin
                if (!rst_b) begin
                    tx_link[li]        <= '0;
                    relay_code_err[li] <= 1'b0;
                    relay_disp_err[li] <= 1'b0;
                    overrun_flag[li]   <= 1'b0;
                    underrun_flag[li]  <= 1'b0;
                end else begin
                    tx_link[li]        <= tx_next;
                    // checks only reported for byte relay
                    relay_code_err[li] <= relay & ~tbi_relay & rx_link[li].valid &
                                          rx_link[li].code_err;
                    relay_disp_err[li] <= relay & ~tbi_relay & rx_link[li].valid &
                                          rx_link[li].disp_err;
                    // a new event outranks a clear in the same cycle
                    if (ovr_evt) begin
                        overrun_flag[li] <= 1'b1;
                    end else if (flag_clear) begin
                        overrun_flag[li] <= 1'b0;
                    end
                    if (und_evt) begin
                        underrun_flag[li] <= 1'b1;
                    end else if (flag_clear) begin
                        underrun_flag[li] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

endmodule // transceiver_startup_repeater_ctrl

/* xcvr_ctrl_asserts.sv */
`timescale 1ns/100ps
// =====
// startup sequencer and relay checker
module xcvr_ctrl_checker
    import xcvr_ctrl_pkg::*;
(
    input wire logic           core_clk,
    input wire logic           rst_b,
    input wire cfg_t           cfg_pins,
    input wire link_rx_t [1:0] rx_link,
    input wire logic [1:0]     tx_slot,
    input wire startup_state_t startup_state,
    input wire status_t        status,
    input wire steer_t         steer,
    input wire link_tx_t [1:0] tx_link,
    input wire logic [1:0]     relay_code_err
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    startup_state_t prev_reg; // state at the last edge
    logic [11:0]    len_reg;  // cycles spent in prev_reg
    wire            hs   = cfg_pins.half_speed_enable;
    wire            left = startup_state != prev_reg;

    // =====
    // run length of each state; a counter, since repetition cannot reach 3298
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            prev_reg <= ST_WAIT_CLK;
            len_reg  <= 12'h000;
        end else begin
            prev_reg <= startup_state;
            len_reg  <= left ? 12'h001 : len_reg + 12'h001;
        end
    end

    // =====
    // step lengths, order and standby
    a_pll_len: assert property (
        prev_reg == ST_PLL && left && startup_state != ST_WAIT_CLK
        |-> len_reg == (hs ? 12'hCE2 : 12'h8E2)) else $error("pll step length wrong");
    a_rxi_len: assert property (
        prev_reg == ST_RX_INIT && startup_state inside {ST_WORD_AL, ST_RUN}
        |-> len_reg == (hs ? 12'h01E : 12'h00F)) else $error("rx init length wrong");
    a_run_entry: assert property (
        startup_state == ST_RUN && left |-> prev_reg inside {ST_RX_INIT, ST_WORD_AL})
        else $error("run entered from wrong state");
    a_stby_exit: assert property (
        prev_reg == ST_STANDBY && left |-> startup_state == ST_RX_INIT)
        else $error("standby left to wrong state");
    a_stby_out: assert property (
        startup_state == ST_STANDBY |-> status.serial_tx_disable
        && !status.core_clock_enable && status.pll_locked) else $error("standby outputs");
    // =====
    // steering follows the synced pins
    a_refclk_sel: assert property (
        $stable(cfg_pins.diff_refclk_select) [*5]
        |-> steer.refclk_diff_used == cfg_pins.diff_refclk_select) else $error("refclk pick");
    a_coder_bypass: assert property (
        (cfg_pins.relay_mode_enable && cfg_pins.ten_bit_passthrough_enable) [*5]
        |-> steer.encoder_bypass && !steer.disparity_check_en) else $error("no bypass");
    a_recovered_clock_timing_enable_ignored: assert property (
        cfg_pins.relay_mode_enable [*5] |-> !steer.tx_recovered_timing)
        else $error("relay on recovered timing");
    // =====
    // relay traffic
    a_code_report: assert property (
        relay_code_err[0] |-> $past(rx_link[0].code_err) || $past(rx_link[0].code_err, 2))
        else $error("code error without cause");
    a_slot_timing: assert property (
        tx_link[1].valid |-> $past(tx_slot[1]) || $past(tx_slot[1], 2))
        else $error("transmit without slot");

    c_standby: cover property (startup_state == ST_STANDBY);
    c_relay_tx: cover property (tx_link[0].valid);
    c_code_err: cover property (relay_code_err[0]);
endmodule // xcvr_ctrl_checker

bind transceiver_startup_repeater_ctrl xcvr_ctrl_checker xcvr_ctrl_checker_inst (
    .core_clk, .rst_b, .cfg_pins, .rx_link, .tx_slot, .startup_state, .status,
    .steer, .tx_link, .relay_code_err);

/* link_far_end.sv */
`timescale 1ns/100ps
`include "xcvr_ctrl_params.svh"
// =====
// far end: reference clock source and the two link sources
module link_far_end
    import xcvr_ctrl_pkg::*;
(
    input  wire logic      core_clk,
    output logic           refclk_p,
    output logic           refclk_s,
    output link_rx_t [1:0] rx_out
);
    logic clk_on = 1'b0; // reference clock applied

    initial begin
        refclk_p = 1'b0;
        refclk_s = 1'b0;
        rx_out   = '0;
    end

    // toggles only while applied, stands still otherwise
    always @(negedge core_clk) begin
        if (clk_on) begin
            refclk_p <= ~refclk_p;
            refclk_s <= ~refclk_s;
        end
    end

    // one unit; released fields flip so stale values never match
    task automatic send(int li, logic [9:0] g, logic [7:0] d, logic k, logic ce);
        rx_out[li] = {1'b1, g, d, k, ce, ce};
        @(negedge core_clk);
        rx_out[li] = ~rx_out[li];
        rx_out[li].valid = 1'b0;
    endtask

    // eight idle groups: four for the relay, four for the far receiver
    task automatic idles(int li);
        repeat (8) begin
            rx_out[li] = {1'b1, `IDLE_GROUP_NEG, `IDLE_BYTE, 1'b1, 2'b00};
            @(negedge core_clk);
        end
        rx_out[li].valid = 1'b0;
    endtask

    // word sync sent twice: once for the relay, once for the far receiver
    task automatic word_syncs(int li);
        repeat (2) idles(li);
    endtask
endmodule // link_far_end

/* transceiver_startup_repeater_ctrl_bench.sv */
`timescale 1ns/100ps
// =====
// bench: cold start, standby, reset restart, relay traffic
module transceiver_startup_repeater_ctrl_bench
    import xcvr_ctrl_pkg::*;
;
    logic           core_clk;
    logic           rst_b;
    logic [1:0]     tx_slot;
    cfg_t           cfg;
    link_tx_t [1:0] tx_link;
    link_rx_t [1:0] rx_link;
    logic           ref_d;
    logic           ref_s;
    startup_state_t st;
    status_t        status;
    steer_t         steer;
    logic [1:0]     code_err;
    logic [1:0]     disp_err;
    logic [1:0]     ovr;
    logic [1:0]     und;
    int             error_cnt = 0;
    int             n_compared = 0;

    transceiver_startup_repeater_ctrl transceiver_startup_repeater_ctrl_inst (
        .core_clk, .rst_b, .refclk_diff_pin(ref_d), .refclk_se_pin(ref_s), .cfg_pins(cfg),
        .rx_link, .local_tx('0), .tx_slot, .flag_clear(1'b0), .startup_state(st), .status,
        .steer, .tx_link, .relay_code_err(code_err), .relay_disp_err(disp_err),
        .overrun_flag(ovr), .underrun_flag(und));
    link_far_end link_far_end_inst (.core_clk, .refclk_p(ref_d), .refclk_s(ref_s),
        .rx_out(rx_link));

    // 50 MHz
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    // =====
    // checks and access tasks
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch %s expected %0h seen %0h", nm, e, g);
        end
    endtask

    // wait for state s, then count its cycles; both waits bounded
    task automatic step(startup_state_t s, logic [31:0] e);
        int w;
        int n;
        w = 0;
        n = 0;
        while (st !== s && w < 4000) begin
            @(negedge core_clk);
            w++;
        end
        while (st === s && n < 4000) begin
            @(negedge core_clk);
            n++;
        end
        chk("step", e, n);
    endtask

    // pins pass two sync flops and a steering flop
    task automatic settle;
        repeat (6) @(negedge core_clk);
    endtask

    // one unit through link li, slot given the cycle after it arrives
    task automatic relay(int li, logic [9:0] g, logic [7:0] d, logic tb, logic ce);
        int         n;
        logic [1:0] e;
        n = 0;
        link_far_end_inst.send(li, g, d, 1'b0, ce);
        e = {code_err[li], disp_err[li]};
        tx_slot[li] = 1'b1;
        @(negedge core_clk);
        tx_slot[li] = 1'b0;
        e = e | {code_err[li], disp_err[li]};
        chk("code_disp_err", {2{ce & ~tb}}, e);
        while (tx_link[li].valid !== 1'b1 && n < 4) begin
            @(negedge core_clk);
            n++;
        end
        chk("tx", tb ? g : d, tb ? tx_link[li].group : tx_link[li].data);
    endtask

    task automatic complete_run;
        $display("compared %0d errors %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // =====
    // main sequence
    initial begin
        rst_b = 1'b0;
        tx_slot = 2'b00;
        cfg = '0;
        cfg.diff_refclk_select = 1'b1;
        cfg.rx_clk_center_select = 1'b1;
        repeat (3) @(negedge core_clk);
        rst_b = 1'b1;
        repeat (20) @(negedge core_clk);
        chk("no_clk", ST_WAIT_CLK, st);
        link_far_end_inst.clk_on = 1'b1;
        step(ST_PLL, 32'h8E2);
        step(ST_RX_INIT, 32'hF);
        chk("run", ST_RUN, st);
        chk("steer", 7'h54, steer);
        // standby with word sync on; pll must stay locked
        cfg.word_sync_select_hi = 1'b1;
        cfg.low_power_hold = 1'b1;
        settle;
        chk("stby", {ST_STANDBY, 3'b101}, {st, status[1:0], status[5]});
        cfg.low_power_hold = 1'b0;
        step(ST_RX_INIT, 32'hF);
        step(ST_WORD_AL, 32'h8);
        chk("run", ST_RUN, st);
        // relay at half speed, restarted by reset
        cfg.relay_mode_enable = 1'b1;
        cfg.ten_bit_passthrough_enable = 1'b1;
        cfg.byte_align_enable = 1'b1;
        cfg.idle_insert_remove_enable = 1'b1;
        cfg.recovered_clock_timing_enable = 1'b1;
        cfg.half_speed_enable = 1'b1;
        cfg.diff_refclk_select = 1'b0;
        rst_b = 1'b0;
        #1;
        chk("rst", ST_WAIT_CLK, st);
        @(negedge core_clk);
        rst_b = 1'b1;
        step(ST_PLL, 32'hCE2);
        step(ST_RX_INIT, 32'h1E);
        step(ST_WORD_AL, 32'h10);
        chk("steer", 7'h26, steer);
        for (int li = 0; li < 2; li++) begin
            link_far_end_inst.idles(li);
            link_far_end_inst.word_syncs(li);
            // two slots: drain the held idle, then repeat it with no underrun
            tx_slot[li] = 1'b1;
            repeat (2) @(negedge core_clk);
            tx_slot[li] = 1'b0;
            relay(li, li ? 10'h15A : 10'h2A5, 8'h5A, 1'b1, 1'b1);
        end
        // byte relay decodes and reports errors
        cfg.ten_bit_passthrough_enable = 1'b0;
        settle;
        chk("byte", 2'b01, {steer.encoder_bypass, steer.disparity_check_en});
        relay(0, 10'h000, 8'hC3, 1'b0, 1'b1);
        relay(1, 10'h000, 8'h3C, 1'b0, 1'b0);
        cfg.byte_align_enable = 1'b0;
        settle;
        chk("cfg_err", 1'b1, steer.relay_cfg_error);
        chk("drift", 4'h0, {ovr, und});
        complete_run;
    end

    // hang guard, well beyond the roughly 6000 cycles of the sequence
    initial begin
        repeat (20000) @(negedge core_clk);
        error_cnt++;
        complete_run;
    end
endmodule // transceiver_startup_repeater_ctrl_bench
